// ===== hw/msc_scanner.sv
// memory scan checker: apb registers, scan engine, debug hooks
//
// Summary of operation
// (RULE1) scan starts three cycles after enable written; cpu keeps running meanwhile
// (RULE2) priority mode: scanner owns flash, cpu stalled until scan ends
// (RULE3) one 16-bit word every third cycle, boot scan at boot rate
// (RULE4) checksum is the last two section bytes, high byte first
// (RULE5) boot pass: cpu released, enable one, source shown, pass one
// (RULE6) boot fail: cpu held, enable one, source shown, pass zero
// (RULE7) checksum mismatch clears the pass flag
// (RULE8) fatal irq raised when pass clears with enable; held until reset
// (RULE9) fatal irq enable set by software, cleared only by system reset
// (RULE10) fatal irq enable accepts one only while not busy
// (RULE11) scan halts in sleep and resumes on wake
// (RULE12) sleep during start delay defers start; irq held until done
// (RULE13) debugger memory access suspends; restart on internal access
// (RULE14) suspended scan keeps busy shown but does no checking
// (RULE15) debug mirror of flags readable without suspending, ensures enabled
// (RULE16) debugger busy write zero cancels, one queues a single scan
// (RULE17) while busy, mode/source and irq enable writes ignored
// (RULE18) debugger pass write zero fires fatal irq; then writes ignored
// (RULE19) debugger pass write one reads as one when not busy
// (RULE20) self reset strobe clears registers next cycle except irq enable
// (RULE21) self reset always allowed if irq enable zero, else when idle
// (RULE22) enable stays one after scan, rewrite one restarts, zero ignored
// (RULE23) crc-16-ccitt, msb first from byte zero, init all ones
// (RULE24) source: 0 whole flash, 1 boot plus app, 2 boot only
// (RULE25) pass reads one by default, valid only when not busy
// (RULE26) pass only when crc over section and checksum gives residue
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
module msc_scanner #(
    parameter int AW = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // debugger side
    input wire logic dbgWrite,
    input wire logic dbgMemAccess,
    input wire logic dbgInternalAccess,
    input wire logic dbgDisconnect,
    // system state and fuses
    input wire logic cpuSleep,
    input wire logic bootScanRequest,
    input wire logic [1:0] bootScanSource,
    input wire logic [7:0] bootEndFuse,
    input wire logic [7:0] appEndFuse,
    input wire logic [AW-1:0] lastFlashByte,
    // flash port
    output logic flashReq,
    output logic [AW-1:0] flashAddr,
    input wire logic [15:0] flashData,
    // cpu and interrupt
    output logic cpuStall,
    output logic cpuHold,
    output logic irqDefer,
    output logic fatalIrq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_BOOT, ST_DELAY, ST_FETCH, ST_DONE
    } msc_state_e;

    typedef struct packed {
        msc_state_e st;
        logic enable;
        logic fatalEn;
        logic [1:0] mode;
        logic [1:0] src;
        logic busy;
        logic pass;
        logic fired;
        logic suspended;
        logic fromBoot;
        logic bootFail;
        logic bootDone;
        logic strobe;
        logic [1:0] count;
        logic [AW-1:0] addr;
        logic [15:0] crc;
        logic fetchPend;
        logic [31:0] rdata;
    } msc_s;

    msc_s s_reg;
    msc_s s_next;
    logic [15:0] crcNext;
    logic [AW-1:0] lastByte;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    msc_crc_step u_crc (
        .crcIn(s_reg.crc),
        .word(flashData),
        .crcOut(crcNext)
    );

    msc_bounds #(.AW(AW)) u_bounds (
        .sectionSelect(s_reg.src),
        .bootEndFuse(bootEndFuse),
        .appEndFuse(appEndFuse),
        .lastFlashByte(lastFlashByte),
        .lastByte(lastByte)
    );

    // apb strobes; the slave answers in the access cycle
    logic access;
    logic wr;
    logic blocked;
    logic halt;
    logic period1;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign blocked = s_reg.fired; // [RULE18]
    assign halt = cpuSleep || s_reg.suspended; // [RULE11] [RULE14]
    assign period1 = s_reg.fromBoot;

    function automatic logic isAddr(input logic [11:0] a,
                                    input logic [11:0] r);
        isAddr = (a == r);
    endfunction : isAddr

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] wd;
        logic [1:0] lim;
        wd = pwdata[7:0];
        lim = s_reg.fromBoot ? 2'(msc_pkg::BOOT_FETCH_PERIOD_CYCLES - 1)
                             : 2'(msc_pkg::FETCH_PERIOD_CYCLES - 1);
        s_next = s_reg;
        s_next.strobe = 1'b0; // strobe never holds its value [RULE20]

        // pending self reset clears state, enable, mode, source, busy, pass and suspend; irq enable kept [RULE20]
        if (s_reg.strobe) begin
            s_next.st = ST_IDLE;
            s_next.enable = 1'b0;
            s_next.mode = 2'h0;
            s_next.src = 2'h0;
            s_next.busy = 1'b0;
            s_next.pass = 1'b0;
            s_next.fetchPend = 1'b0;
            s_next.suspended = 1'b0;
        end

        // debugger suspend and restart [RULE13]
        if (dbgMemAccess) begin
            s_next.suspended = 1'b1;
        end else if (s_reg.suspended &&
                     (dbgInternalAccess || dbgDisconnect)) begin
            s_next.suspended = 1'b0;
            if (s_reg.busy) begin
                s_next.st = ST_DELAY;
                s_next.count = 2'h0;
            end
        end

        // scan engine
        case (s_reg.st)
            ST_IDLE: begin
                s_next.count = 2'h0;
            end
            ST_BOOT: begin
                // boot scan begins at once, boot fetch rate [RULE3]
                s_next.st = ST_FETCH;
            end
            ST_DELAY: begin
                // three idle cycles, frozen during sleep [RULE1] [RULE12]
                if (!halt) begin
                    if (s_reg.count == 2'(msc_pkg::START_DELAY_CYCLES - 1))
                        begin
                        s_next.st = ST_FETCH;
                        s_next.count = 2'h0;
                        s_next.addr = '0;
                        s_next.crc = msc_pkg::CRC_INIT; // [RULE23]
                    end else begin
                        s_next.count = s_reg.count + 2'h1;
                    end
                end
            end
            ST_FETCH: begin
                if (!halt) begin
                    // one word per fetch period [RULE3]
                    if (s_reg.count == lim) begin
                        s_next.count = 2'h0;
                        s_next.crc = crcNext; // [RULE23] [RULE4]
                        s_next.addr = s_reg.addr + AW'(2);
                        if (s_reg.addr + AW'(1) >= lastByte) begin
                            s_next.st = ST_DONE;
                        end
                    end else begin
                        s_next.count = s_reg.count + 2'h1;
                    end
                end
            end
            ST_DONE: begin
                s_next.st = ST_IDLE;
                s_next.busy = 1'b0;
                s_next.fromBoot = 1'b0;
                s_next.bootDone = 1'b1;
                // residue compare [RULE26] [RULE7]
                if (s_reg.crc == msc_pkg::CRC_RESIDUE) begin
                    s_next.pass = 1'b1;
                end else begin
                    s_next.pass = 1'b0;
                    s_next.bootFail = s_reg.fromBoot; // [RULE6]
                end
            end
            default: s_next.st = ST_IDLE;
        endcase

        // boot request: enable one, source shown [RULE5] [RULE6]
        if (bootScanRequest && !s_reg.bootDone && s_reg.st == ST_IDLE) begin
            s_next.st = ST_BOOT;
            s_next.enable = 1'b1;
            s_next.src = bootScanSource;
            s_next.busy = 1'b1;
            s_next.fromBoot = 1'b1;
            s_next.addr = '0;
            s_next.crc = msc_pkg::CRC_INIT;
            s_next.count = 2'h0;
        end

        // register writes, all refused once fatal irq fired [RULE18]
        if (wr && !blocked && !s_reg.strobe) begin
            if (isAddr(paddr, msc_pkg::ADDR_CONTROL)) begin
                if (wd[msc_pkg::CTL_RESET_BIT] &&
                    (!s_reg.fatalEn || !s_reg.busy)) begin
                    s_next.strobe = 1'b1; // [RULE21]
                end
                if (wd[msc_pkg::CTL_FATAL_EN_BIT] && !s_reg.busy) begin
                    s_next.fatalEn = 1'b1; // [RULE9] [RULE10] [RULE17]
                end
                if (wd[msc_pkg::CTL_ENABLE_BIT] && !s_reg.busy) begin
                    s_next.enable = 1'b1; // zero write ignored [RULE22]
                    s_next.busy = 1'b1;
                    s_next.st = ST_DELAY; // [RULE1]
                    s_next.count = 2'h0;
                end
            end else if (isAddr(paddr, msc_pkg::ADDR_MODE_SOURCE)) begin
                if (!s_reg.busy) begin // [RULE17]
                    s_next.src = wd[msc_pkg::SRC_LSB +: 2]; // [RULE24]
                    s_next.mode = wd[msc_pkg::MODE_LSB +: 2];
                end
            end else if (isAddr(paddr, msc_pkg::ADDR_RESULT_FLAGS) &&
                         dbgWrite) begin
                // debugger status writes [RULE16]
                if (!wd[msc_pkg::FLG_BUSY_BIT]) begin
                    s_next.busy = 1'b0;
                    s_next.st = ST_IDLE;
                end else if (!s_reg.busy) begin
                    s_next.busy = 1'b1;
                    s_next.st = ST_DELAY;
                    s_next.count = 2'h0;
                end
                s_next.pass = wd[msc_pkg::FLG_PASS_BIT]; // [RULE18] [RULE19]
            end
        end

        // fatal irq latch, set wins and holds to reset [RULE8]
        if (s_reg.fatalEn && s_reg.pass && !s_next.pass) begin
            s_next.fired = 1'b1;
        end

        // read data copy registered at the end of the access cycle; prdata does not use it
        s_next.rdata = 32'h0000_0000;
        if (access && !pwrite) begin
            if (isAddr(paddr, msc_pkg::ADDR_CONTROL)) begin
                s_next.rdata[msc_pkg::CTL_ENABLE_BIT] = s_reg.enable;
                s_next.rdata[msc_pkg::CTL_FATAL_EN_BIT] = s_reg.fatalEn;
            end else if (isAddr(paddr, msc_pkg::ADDR_MODE_SOURCE)) begin
                s_next.rdata[msc_pkg::SRC_LSB +: 2] = s_reg.src;
                s_next.rdata[msc_pkg::MODE_LSB +: 2] = s_reg.mode;
            end else if (isAddr(paddr, msc_pkg::ADDR_RESULT_FLAGS) ||
                         isAddr(paddr, msc_pkg::ADDR_DEBUG_MIRROR)) begin
                // busy and pass read as stored, flags and mirror alike [RULE25] [RULE15]
                s_next.rdata[msc_pkg::FLG_BUSY_BIT] = s_reg.busy;
                s_next.rdata[msc_pkg::FLG_PASS_BIT] = s_reg.pass;
            end
        end
        // mirror read wakes a suspended scan [RULE15]
        if (access && !pwrite && isAddr(paddr, msc_pkg::ADDR_DEBUG_MIRROR)
            && !dbgMemAccess) begin
            s_next.suspended = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{st: ST_IDLE, enable: 1'b0, fatalEn: 1'b0,
                       mode: 2'h0, src: 2'h0,
                       busy: msc_pkg::RESULT_FLAGS_RESET[0],
                       pass: msc_pkg::RESULT_FLAGS_RESET[1],
                       fired: 1'b0, suspended: 1'b0, fromBoot: 1'b0,
                       bootFail: 1'b0, bootDone: 1'b0, strobe: 1'b0,
                       count: 2'h0, addr: '0, crc: msc_pkg::CRC_INIT,
                       fetchPend: 1'b0, rdata: 32'h0000_0000};
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the apb slave answers in the first access cycle; read data is
    // captured one edge earlier is not possible, so prdata is muxed
    // zero-wait reads mux the live s_reg state directly, not the rdata copy
    always_comb begin
        prdata = 32'h0000_0000;
        if (isAddr(paddr, msc_pkg::ADDR_CONTROL)) begin
            prdata[msc_pkg::CTL_ENABLE_BIT] = s_reg.enable;
            prdata[msc_pkg::CTL_FATAL_EN_BIT] = s_reg.fatalEn;
        end else if (isAddr(paddr, msc_pkg::ADDR_MODE_SOURCE)) begin
            prdata[msc_pkg::SRC_LSB +: 2] = s_reg.src;
            prdata[msc_pkg::MODE_LSB +: 2] = s_reg.mode;
        end else if (isAddr(paddr, msc_pkg::ADDR_RESULT_FLAGS) ||
                     isAddr(paddr, msc_pkg::ADDR_DEBUG_MIRROR)) begin
            prdata[msc_pkg::FLG_BUSY_BIT] = s_reg.busy;
            prdata[msc_pkg::FLG_PASS_BIT] = s_reg.pass;
        end
    end
    assign pready = 1'b1;
    assign pslverr = access && !(isAddr(paddr, msc_pkg::ADDR_CONTROL) ||
                     isAddr(paddr, msc_pkg::ADDR_MODE_SOURCE) ||
                     isAddr(paddr, msc_pkg::ADDR_RESULT_FLAGS) ||
                     isAddr(paddr, msc_pkg::ADDR_DEBUG_MIRROR));
    // scanner owns flash while fetching [RULE2]
    assign flashReq = (s_reg.st == ST_FETCH) && !halt;
    assign flashAddr = s_reg.addr;
    assign cpuStall = (s_reg.st == ST_FETCH) || (s_reg.st == ST_DONE)
                      || (s_reg.st == ST_BOOT); // [RULE2]
    // boot result gates cpu start [RULE5] [RULE6]
    assign cpuHold = s_reg.fromBoot || s_reg.bootFail;
    assign irqDefer = s_reg.busy && (s_reg.st != ST_IDLE); // [RULE12]
    assign fatalIrq = s_reg.fired; // [RULE8]

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_enWrite;
        wr && !blocked && !s_reg.strobe && !s_reg.busy && !halt &&
        isAddr(paddr, msc_pkg::ADDR_CONTROL) &&
        pwdata[msc_pkg::CTL_ENABLE_BIT] && !pwdata[msc_pkg::CTL_RESET_BIT]
        && !dbgMemAccess && !bootScanRequest;
    endsequence
    property p_start_delay;
        @(posedge clk) disable iff (rst)
        s_enWrite ##1 (!halt && !dbgMemAccess)[*4] |-> flashReq;
    endproperty
    a_start_delay: assert property (p_start_delay) // [RULE1]
        else $error("scan did not start three cycles after enable");
    property p_no_early;
        @(posedge clk) disable iff (rst)
        s_enWrite |=> !flashReq ##1 !flashReq ##1 !flashReq;
    endproperty
    a_no_early: assert property (p_no_early) // [RULE1]
        else $error("scan started early");
    property p_stall;
        @(posedge clk) disable iff (rst) flashReq |-> cpuStall;
    endproperty
    a_stall: assert property (p_stall) // [RULE2]
        else $error("cpu not stalled during fetch");
    property p_irq_sticky;
        @(posedge clk) disable iff (rst) fatalIrq |=> fatalIrq;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) // [RULE8]
        else $error("fatal irq dropped");
    property p_fen_sticky;
        @(posedge clk) disable iff (rst) s_reg.fatalEn |=> s_reg.fatalEn;
    endproperty
    a_fen_sticky: assert property (p_fen_sticky) // [RULE9]
        else $error("irq enable cleared without reset");
    property p_irq_cause;
        @(posedge clk) disable iff (rst)
        $rose(fatalIrq) |-> $past(s_reg.fatalEn) && $fell(s_reg.pass);
    endproperty
    a_irq_cause: assert property (p_irq_cause) // [RULE8]
        else $error("fatal irq without pass clearing");
    property p_src_lock;
        @(posedge clk) disable iff (rst)
        s_reg.busy && !s_reg.strobe && !bootScanRequest |=>
            $stable(s_reg.src) || s_reg.strobe;
    endproperty
    a_src_lock: assert property (p_src_lock) // [RULE17]
        else $error("source changed while busy");
    property p_strobe;
        @(posedge clk) disable iff (rst)
        s_reg.strobe && !bootScanRequest |=> !s_reg.enable && !s_reg.busy
            && !s_reg.strobe;
    endproperty
    a_strobe: assert property (p_strobe) // [RULE20]
        else $error("self reset did not clear registers");
    property p_sleep_halt;
        @(posedge clk) disable iff (rst)
        cpuSleep |-> !flashReq;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) // [RULE11]
        else $error("fetch during sleep");
endmodule : msc_scanner

// ===== hw/msc_pkg.sv
// package of constants for the memory scan checker
package msc_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_MODE_SOURCE = 12'h004;
    localparam logic [11:0] ADDR_RESULT_FLAGS = 12'h008;
    localparam logic [11:0] ADDR_DEBUG_MIRROR = 12'h00C;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_FATAL_EN_BIT = 1;
    localparam int CTL_RESET_BIT = 7;
    localparam int SRC_LSB = 0;
    localparam int MODE_LSB = 4;
    localparam int FLG_BUSY_BIT = 0;
    localparam int FLG_PASS_BIT = 1;
    // ------------------------------------------------------------
    // reset values, encodings and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RESULT_FLAGS_RESET = 8'h02;
    localparam logic [1:0] SRC_WHOLE_FLASH = 2'h0;
    localparam logic [1:0] SRC_BOOT_APP = 2'h1;
    localparam logic [1:0] SRC_BOOT_ONLY = 2'h2;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    localparam int START_DELAY_CYCLES = 3;
    localparam int FETCH_PERIOD_CYCLES = 3;
    localparam int BOOT_FETCH_PERIOD_CYCLES = 1;
    localparam int FUSE_PAGE_BYTES = 256;
endpackage : msc_pkg

// ===== hw/msc_crc_step.sv
// one-word crc-16 update, two bytes msb first
`timescale 1ns/100ps
module msc_crc_step (
    // input checksum and word
    input wire logic [15:0] crcIn,
    input wire logic [15:0] word,
    // updated checksum
    output logic [15:0] crcOut
);
    // high byte goes first, each byte shifted in msb first
    always_comb begin
        logic [15:0] c;
        c = crcIn;
        for (int i = 15; i >= 0; i--) begin
            if (c[15] ^ word[i]) begin
                c = {c[14:0], 1'b0} ^ msc_pkg::CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        crcOut = c;
    end
endmodule : msc_crc_step

// ===== hw/msc_bounds.sv
// section end lookup from source select and fuses
`timescale 1ns/100ps
module msc_bounds #(
    parameter int AW = 14
) (
    // selection and fuse values
    input wire logic [1:0] sectionSelect,
    input wire logic [7:0] bootEndFuse,
    input wire logic [7:0] appEndFuse,
    input wire logic [AW-1:0] lastFlashByte,
    // byte address of the last checked byte
    output logic [AW-1:0] lastByte
);
    // fuse end times a page, minus one, gives the last byte
    always_comb begin
        logic [AW+8:0] page;
        page = '0;
        if (sectionSelect == msc_pkg::SRC_BOOT_ONLY) begin
            page = (AW+9)'(bootEndFuse) * (AW+9)'(msc_pkg::FUSE_PAGE_BYTES);
            lastByte = AW'(page - (AW+9)'(1));
        end else if (sectionSelect == msc_pkg::SRC_BOOT_APP) begin
            page = (AW+9)'(appEndFuse) * (AW+9)'(msc_pkg::FUSE_PAGE_BYTES);
            lastByte = AW'(page - (AW+9)'(1));
        end else begin
            lastByte = lastFlashByte;
        end
    end
endmodule : msc_bounds

// ===== dv/msc_flash_model.sv
// program flash model answering the scanner's word fetches
`timescale 1ns/100ps
module msc_flash_model (
    // clock
    input wire logic clk,
    // fetch port
    input wire logic flashReq,
    input wire logic [13:0] flashAddr,
    output logic [15:0] flashData
);
    logic [7:0] mem [0:255];
    logic [15:0] junk = 16'hA5C3;
    // junk moves every cycle so an unrequested sample never looks valid
    always @(posedge clk) junk <= ~{junk[14:0], junk[15]};
    // high byte sits at the lower address
    always_comb begin
        if (flashReq)
            flashData = {mem[flashAddr[7:0]], mem[flashAddr[7:0] + 8'h01]};
        else
            flashData = junk;
    end
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
endmodule : msc_flash_model

// ===== dv/testbench.sv
// self-checking bench for the memory scan checker
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, slv, dbgWrite = 1'b0, cpuSleep = 1'b0;
    logic bootReq = 1'b0, flashReq, cpuStall, cpuHold, irqDefer, fatalIrq;
    logic dbgMem = 1'b0;
    logic [1:0] bootSrc = 2'h2;
    logic [7:0] boot_end_fuse = 8'h01;
    logic [13:0] flashAddr;
    logic [15:0] flashData;
    int numErrors = 0, testsRun = 0, n;
    // ------------------------------------------------------------
    // clock, design and flash
    // ------------------------------------------------------------
    initial forever #20 clk = ~clk;
    msc_scanner #(.AW(14)) i_dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dbgWrite(dbgWrite), .dbgMemAccess(dbgMem), .dbgInternalAccess(1'b0),
        .dbgDisconnect(1'b0), .cpuSleep(cpuSleep), .bootScanRequest(bootReq),
        .bootScanSource(bootSrc), .bootEndFuse(boot_end_fuse),
        .appEndFuse(8'h02), .lastFlashByte(14'h00FF), .flashReq(flashReq),
        .flashAddr(flashAddr), .flashData(flashData), .cpuStall(cpuStall),
        .cpuHold(cpuHold), .irqDefer(irqDefer), .fatalIrq(fatalIrq));
    msc_flash_model i_flash (.clk(clk), .flashReq(flashReq),
        .flashAddr(flashAddr), .flashData(flashData));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic sysReset();
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask : sysReset
    // poll the flags until busy drops; a limit of 3000 polls bounds a hang
    task automatic waitIdle();
        n = 0;
        do begin
            apb(1'b0, msc_pkg::ADDR_RESULT_FLAGS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 3000);
    endtask : waitIdle
    // stored checksum closes the 256-byte boot section
    task automatic seal();
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < 254; i++)
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ i_flash.mem[i][b]) ? 16'h1021
                    : 16'h0000);
        i_flash.mem[254] = c[15:8];
        i_flash.mem[255] = c[7:0];
    endtask : seal
    task automatic rdChk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdChk
    task automatic endOfTest();
        if (numErrors == 0 && testsRun > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : endOfTest
    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        endOfTest();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        sysReset();
        rdChk("control", msc_pkg::ADDR_CONTROL, 32'h0);
        rdChk("flags", msc_pkg::ADDR_RESULT_FLAGS, 32'h2);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", {31'h0, slv}, 32'h1);
        // good boot-only scan from software
        seal();
        apb(1'b1, msc_pkg::ADDR_MODE_SOURCE, 32'h2);
        apb(1'b1, msc_pkg::ADDR_CONTROL, 32'h1);
        n = 0;
        #1;
        while (flashReq !== 1'b1 && n < 9) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("start delay", n, 32'h3);
        @(posedge clk);
        cpuSleep <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("sleep fetch", {31'h0, flashReq}, 32'h0);
        @(posedge clk);
        cpuSleep <= 1'b0;
        dbgMem <= 1'b1;
        @(posedge clk);
        dbgMem <= 1'b0;
        rdChk("susp busy", msc_pkg::ADDR_RESULT_FLAGS, 32'h3);
        chk("susp fetch", {31'h0, flashReq}, 32'h0);
        chk("stall held", {31'h0, cpuStall}, 32'h1);
        chk("irq deferred", {31'h0, irqDefer}, 32'h1);
        rdChk("mirror", msc_pkg::ADDR_DEBUG_MIRROR, 32'h3);
        apb(1'b1, msc_pkg::ADDR_MODE_SOURCE, 32'h1);
        waitIdle();
        chk("pass", rd, 32'h2);
        rdChk("enable kept", msc_pkg::ADDR_CONTROL, 32'h1);
        rdChk("busy src", msc_pkg::ADDR_MODE_SOURCE, 32'h2);
        // corrupted byte: failure, then debugger writes
        i_flash.mem[7] = ~i_flash.mem[7];
        apb(1'b1, msc_pkg::ADDR_CONTROL, 32'h1);
        waitIdle();
        chk("fail", rd, 32'h0);
        chk("no irq", {31'h0, fatalIrq}, 32'h0);
        dbgWrite <= 1'b1;
        apb(1'b1, msc_pkg::ADDR_RESULT_FLAGS, 32'h2);
        rdChk("dbg pass", msc_pkg::ADDR_RESULT_FLAGS, 32'h2);
        apb(1'b1, msc_pkg::ADDR_CONTROL, 32'h2);
        apb(1'b1, msc_pkg::ADDR_RESULT_FLAGS, 32'h0);
        repeat (2) @(posedge clk);
        chk("fatal irq", {31'h0, fatalIrq}, 32'h1);
        apb(1'b1, msc_pkg::ADDR_MODE_SOURCE, 32'h0);
        rdChk("locked", msc_pkg::ADDR_MODE_SOURCE, 32'h2);
        dbgWrite <= 1'b0;
        // boot scan fails, then passes
        bootReq <= 1'b1;
        sysReset();
        chk("irq cleared", {31'h0, fatalIrq}, 32'h0);
        waitIdle();
        chk("boot fail", rd, 32'h0);
        chk("cpu held", {31'h0, cpuHold}, 32'h1);
        seal();
        sysReset();
        waitIdle();
        chk("boot pass", rd, 32'h2);
        chk("cpu free", {31'h0, cpuHold}, 32'h0);
        rdChk("boot en", msc_pkg::ADDR_CONTROL, 32'h1);
        rdChk("boot src", msc_pkg::ADDR_MODE_SOURCE, 32'h2);
        bootReq <= 1'b0;
        // self reset keeps the irq enable
        apb(1'b1, msc_pkg::ADDR_CONTROL, 32'h2);
        apb(1'b1, msc_pkg::ADDR_CONTROL, 32'h80);
        rdChk("self reset", msc_pkg::ADDR_CONTROL, 32'h2);
        rdChk("self src", msc_pkg::ADDR_MODE_SOURCE, 32'h0);
        apb(1'b1, msc_pkg::ADDR_CONTROL, 32'h0);
        rdChk("irq en kept", msc_pkg::ADDR_CONTROL, 32'h2);
        endOfTest();
    end
endmodule : testbench
